//--- aic_attach_ctrl.sv
/*
 Attach indicator pin control: hardware configuration register slice on
 AHB-Lite, reset protection of the pin fields, cable-triggered detach and
 reattach, and the open-drain or push-pull attach indicator pin.
 Assumes one AHB-Lite master, resets from the device's reset controller on
 ref_clk, and that the pad resolves the pin from out and enable.
*/
// The address map and the AHB-Lite slave port were left to the implementer.
`default_nettype none
// Notes on behaviour
// - Drive type bit 0 makes the pin open drain, 1 makes it push-pull.
// - The pin is driven only while the enable bit is set.
// - With the pin enabled it is asserted while the device tries to attach and no detach is active.
// - The pin also asserts when reattach is attempted after a cable-triggered detach.
// - Enable and polarity only act when the device is configured for HSIC.
// - Polarity bit 0 gives an active-low pin, 1 an active-high pin.
// - With the reset shield bit set, the pin fields keep their values across USB and lite resets.
// - With the shield set only a power-on reset or a register write changes the protected fields.
// - After a cable-triggered detach, link or GPIO reattaches and sets the detach status flag.
// - With the shield clear, a USB or lite reset reloads the drive type bit from the image, or clears it without one.
module aic_attach_ctrl
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire aic_pkg::aic_reset_src_t resetSrc,
    input wire aic_pkg::aic_image_t imageCfg,
    input wire logic hsicMode,
    input wire logic attachAttempt,
    input wire logic phyLinkUp,
    input wire logic gpioWake,
    output logic detachActive,
    output logic attachPinOut,
    output logic attachPinOe
);
    import aic_pkg::*;

    aic_pin_cfg_t cfg_reg;
    aic_pin_cfg_t cfg_next;
    logic protect_reg;
    logic protect_next;
    logic detSts_reg;
    logic detSts_next;
    logic [11:0] wrAddr_reg;
    logic [11:0] wrAddr_next;
    logic wrPend_reg;
    logic wrPend_next;
    logic [31:0] rdData_reg;
    logic [31:0] rdData_next;
    logic linkSync;
    logic gpioSync;
    logic reattachEvt;
    logic wrHit;
    logic assertLvl;
    logic [31:0] regView;

    typedef enum {ST_ATTACHED, ST_DETACHED} aic_det_state_t;
    aic_det_state_t det_reg;
    aic_det_state_t det_next;

    // Pins from outside the clock domain
    aic_sync linkSyncI
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .asyncIn(phyLinkUp),
        .syncOut(linkSync)
    );
    aic_sync gpioSyncI
    (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .asyncIn(gpioWake),
        .syncOut(gpioSync)
    );

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdData_reg;

    always_comb
    begin
        regView = '0;
        regView[AIC_POL_BIT] = cfg_reg.activeHigh;
        regView[AIC_EN_BIT] = cfg_reg.pinEnable;
        regView[AIC_BUF_BIT] = cfg_reg.bufPushPull;
        regView[AIC_RSV_BIT] = 1'b0;
        regView[AIC_PROT_BIT] = protect_reg;
        regView[AIC_DET_EN_BIT] = 1'b0;
        regView[AIC_DET_STS_BIT] = detSts_reg;
    end

    always_comb
    begin
        wrAddr_next = wrAddr_reg;
        wrPend_next = 1'b0;
        rdData_next = rdData_reg;
        if (hsel && hready && htrans[1])
        begin
            wrPend_next = hwrite;
            wrAddr_next = haddr[11:0];
            if (!hwrite)
                rdData_next = (haddr[11:0] == AIC_HWCFG_OFF) ? regView : 32'h0000_0000;
        end
    end

    assign wrHit = wrPend_reg && (wrAddr_reg == AIC_HWCFG_OFF);
    assign reattachEvt = (det_reg == ST_DETACHED) && (linkSync || gpioSync);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            wrAddr_reg <= 12'h000;
            wrPend_reg <= 1'b0;
            rdData_reg <= 32'h0000_0000;
        end
        else
        begin
            wrAddr_reg <= wrAddr_next;
            wrPend_reg <= wrPend_next;
            rdData_reg <= rdData_next;
        end
    end

    // Protected fields: shield lets only power-on reset and register writes touch them
    always_comb
    begin
        cfg_next = cfg_reg;
        protect_next = protect_reg;
        detSts_next = detSts_reg;
        det_next = det_reg;
        if (resetSrc.porReset)
        begin
            cfg_next = imageCfg.valid ? aic_pin_cfg_t'(imageCfg[2:0]) : '0;
            protect_next = AIC_FIELD_RESET;
            detSts_next = AIC_FIELD_RESET;
            det_next = ST_ATTACHED;
        end
        else
        begin
            if ((resetSrc.usbReset || resetSrc.liteReset) && !protect_reg)
            begin
                cfg_next.bufPushPull = imageCfg.valid ? imageCfg.bufPushPull : 1'b0;
            end
            else if (wrHit)
            begin
                cfg_next.activeHigh = hwdata[AIC_POL_BIT];
                cfg_next.pinEnable = hwdata[AIC_EN_BIT];
                cfg_next.bufPushPull = hwdata[AIC_BUF_BIT];
                protect_next = hwdata[AIC_PROT_BIT];
            end
            if (wrHit && hwdata[AIC_DET_STS_BIT])
                detSts_next = 1'b0;
            if (wrHit && hwdata[AIC_DET_EN_BIT])
                det_next = ST_DETACHED;
            else if (reattachEvt)
            begin
                det_next = ST_ATTACHED;
                detSts_next = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            // Synchronous reset stands for power-on here
            cfg_reg <= '0;
            protect_reg <= AIC_FIELD_RESET;
            detSts_reg <= AIC_FIELD_RESET;
            det_reg <= ST_ATTACHED;
        end
        else
        begin
            cfg_reg <= cfg_next;
            protect_reg <= protect_next;
            detSts_reg <= detSts_next;
            det_reg <= det_next;
        end
    end

    assign detachActive = (det_reg == ST_DETACHED);

    // Assert while attaching, including the reattach cycle
    assign assertLvl = (attachAttempt && !detachActive) || reattachEvt;

    always_comb
    begin
        attachPinOut = 1'b0;
        attachPinOe = 1'b0;
        if (hsicMode && cfg_reg.pinEnable)
        begin
            attachPinOut = assertLvl ~^ cfg_reg.activeHigh;
            // Open drain only pulls low, never drives high
            attachPinOe = cfg_reg.bufPushPull || !attachPinOut;
        end
    end

    pin_off_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !(hsicMode && cfg_reg.pinEnable) |-> !attachPinOe)
        else $error("attach pin driven while disabled");
    open_drain_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (attachPinOe && !cfg_reg.bufPushPull) |-> !attachPinOut)
        else $error("open drain pin driven high");
    polarity_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (hsicMode && cfg_reg.pinEnable && (!attachAttempt || detachActive) && !reattachEvt)
        |-> (attachPinOut == !cfg_reg.activeHigh))
        else $error("attach pin polarity wrong");
    attach_level_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (hsicMode && cfg_reg.pinEnable && cfg_reg.bufPushPull && attachAttempt && !detachActive)
        |-> attachPinOe && (attachPinOut == cfg_reg.activeHigh))
        else $error("attach not indicated");
    reattach_flag_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (reattachEvt && !resetSrc.porReset && !(wrHit && hwdata[AIC_DET_EN_BIT]))
        |=> detSts_reg && !detachActive)
        else $error("reattach did not set status");
    shield_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (protect_reg && !resetSrc.porReset && !wrHit) |=> (cfg_reg == $past(cfg_reg)))
        else $error("shielded field changed");
    lite_reload_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (resetSrc.liteReset && !protect_reg && !resetSrc.porReset && !imageCfg.valid)
        |=> !cfg_reg.bufPushPull)
        else $error("drive type not cleared");
    rsv_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        $past(hsel && hready && htrans[1] && !hwrite) |-> !hrdata[AIC_RSV_BIT])
        else $error("reserved bit reads one");
    hsic_gate_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !hsicMode |-> !attachPinOe && !attachPinOut)
        else $error("pin active outside HSIC");
    reattach_pin_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (reattachEvt && hsicMode && cfg_reg.pinEnable) |-> (attachPinOut == cfg_reg.activeHigh))
        else $error("reattach not indicated");
endmodule
`default_nettype wire

//--- aic_host_model.sv
/*
 Host side model: pull-up on the attach line and sensing of attach.
 Assumes pin value and enable from the block, enable high while driving.
*/
`default_nettype none
module aic_host_model
(
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic activeHigh,
    output logic lineLevel,
    output logic attachSeen
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line floats up, so open drain high is never driven
    assign lineLevel = pinOe ? pinOut : 1'h1;
    assign attachSeen = lineLevel == activeHigh;
endmodule
`default_nettype wire

//--- aic_pkg.sv
/*
 Package for the attach indicator pin control block: register map, field
 positions, reset values and the carrier structs.
 Assumes a 32-bit AHB-Lite register bus and one 25 MHz clock.
*/
`default_nettype none
package aic_pkg;
    localparam logic [11:0] AIC_HWCFG_OFF = 12'h0010;
    localparam int AIC_POL_BIT = 8;
    localparam int AIC_EN_BIT = 9;
    localparam int AIC_BUF_BIT = 10;
    localparam int AIC_RSV_BIT = 11;
    localparam int AIC_PROT_BIT = 12;
    localparam int AIC_DET_EN_BIT = 14;
    localparam int AIC_DET_STS_BIT = 15;
    localparam logic AIC_FIELD_RESET = 1'b0;
    localparam int AIC_SYNC_STAGES = 2;

    typedef struct packed {
        logic bufPushPull;
        logic pinEnable;
        logic activeHigh;
    } aic_pin_cfg_t;

    typedef struct packed {
        logic valid;
        logic bufPushPull;
        logic pinEnable;
        logic activeHigh;
    } aic_image_t;

    typedef struct packed {
        logic porReset;
        logic usbReset;
        logic liteReset;
    } aic_reset_src_t;
endpackage
`default_nettype wire

//--- aic_sync.sv
/*
 Two-flop synchroniser for one level coming from outside the clock domain.
 Assumes the input is a slow level; no pulse shorter than two clocks.
*/
`default_nettype none
module aic_sync
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic asyncIn,
    output logic syncOut
);
    import aic_pkg::*;
    logic firstReg;
    logic firstNext;
    logic secondReg;
    logic secondNext;

    always_comb
    begin
        firstNext = asyncIn;
        secondNext = firstReg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            firstReg <= AIC_FIELD_RESET;
            secondReg <= AIC_FIELD_RESET;
        end
        else
        begin
            firstReg <= firstNext;
            secondReg <= secondNext;
        end
    end

    assign syncOut = secondReg;
endmodule
`default_nettype wire

//--- tb_top.sv
/*
 Testbench for the attach indicator block: AHB-Lite tasks and directed tests.
 Assumes zero wait states are not relied on; every wait is bounded.
*/
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import aic_pkg::*;
    localparam logic [31:0] CFG = 32'(AIC_HWCFG_OFF);
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic hsel = 1'h0;
    logic hwrite = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout, hresp, detachActive, attachPinOut, attachPinOe, lineLevel;
    aic_reset_src_t resetSrc = 3'h0;
    aic_image_t imageCfg = 4'h0;
    logic hsicMode = 1'h0;
    logic attachAttempt = 1'h0;
    logic phyLinkUp = 1'h0;
    logic gpioWake = 1'h0;
    logic hostPol = 1'h0;
    logic attachSeen;
    int err_total = 0;
    int num_checks = 0;

    always #20 ref_clk = ~ref_clk;

    aic_attach_ctrl u_aic_attach_ctrl (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .resetSrc(resetSrc), .imageCfg(imageCfg), .hsicMode(hsicMode),
        .attachAttempt(attachAttempt), .phyLinkUp(phyLinkUp), .gpioWake(gpioWake), .detachActive(detachActive),
        .attachPinOut(attachPinOut), .attachPinOe(attachPinOe));
    aic_host_model u_aic_host_model (.pinOut(attachPinOut), .pinOe(attachPinOe), .activeHigh(hostPol),
        .lineLevel(lineLevel), .attachSeen(attachSeen));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait on hready; a hang ends the run
    task automatic waitRdy();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (hreadyout !== 1'h1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 50)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        if (!wr)
            rd = hrdata;
        chk(32'(hresp), 32'h0000_0000);
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic pinChk(input logic o, input logic e);
        chk(32'(attachPinOut), 32'(o));
        chk(32'(attachPinOe), 32'(e));
        chk(32'(lineLevel), 32'(e ? o : 1'h1));
    endtask

    task automatic pulse(input aic_reset_src_t s);
        resetSrc <= s;
        @(posedge ref_clk);
        resetSrc <= 3'h0;
        @(posedge ref_clk);
    endtask

    // Wake inputs are synchronised, so allow a few cycles
    task automatic waitAttach();
        int n;
        n = 0;
        while (detachActive !== 1'h0 && n < 20)
        begin
            step();
            n++;
        end
        if (n >= 20)
        begin
            err_total++;
            tally_and_finish();
        end
    endtask

    initial
    begin
        repeat (6) @(posedge ref_clk);
        resetn <= 1'h1;
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0000);
        xfer(1'h0, CFG + 4, 32'h0); chk(rd, 32'h0000_0000);
        xfer(1'h1, CFG, 32'h0000_0F00);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0700);
        $display("test regs done");
        hsicMode <= 1'h1;
        for (int k = 0; k < 8; k++)
        begin
            attachAttempt <= k[2];
            hostPol <= k[0];
            xfer(1'h1, CFG, {21'h0, k[1], 1'h1, k[0], 8'h00});
            step();
            pinChk(k[2] ~^ k[0], k[1] | !(k[2] ~^ k[0]));
            chk(32'(attachSeen), 32'(k[2]));
        end
        xfer(1'h1, CFG, 32'h0000_0500); step(); pinChk(1'h0, 1'h0);
        xfer(1'h1, CFG, 32'h0000_0700);
        hsicMode <= 1'h0;
        step(); pinChk(1'h0, 1'h0);
        hsicMode <= 1'h1;
        $display("test pin done");
        xfer(1'h1, CFG, 32'h0000_1600);
        pulse(3'h2);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_1600);
        xfer(1'h1, CFG, 32'h0000_0600);
        imageCfg <= 4'h8;
        pulse(3'h1);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0200);
        imageCfg <= 4'hC;
        pulse(3'h2);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0600);
        xfer(1'h1, CFG, 32'h0000_1600);
        imageCfg <= 4'hB;
        pulse(3'h4);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0300);
        $display("test shield done");
        step(); pinChk(1'h1, 1'h0);
        xfer(1'h1, CFG, 32'h0000_4300);
        step(); chk(32'(detachActive), 32'h1);
        pinChk(1'h0, 1'h1);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0300);
        phyLinkUp <= 1'h1;
        waitAttach();
        step(); pinChk(1'h1, 1'h0);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_8300);
        xfer(1'h1, CFG, 32'h0000_8300);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0300);
        phyLinkUp <= 1'h0;
        repeat (3) @(posedge ref_clk);
        xfer(1'h1, CFG, 32'h0000_4300);
        step(); chk(32'(detachActive), 32'h1);
        gpioWake <= 1'h1;
        waitAttach();
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_8300);
        $display("test detach done");
        xfer(1'h1, CFG, 32'h0000_8600);
        imageCfg <= 4'h0;
        pulse(3'h1);
        xfer(1'h0, CFG, 32'h0); chk(rd, 32'h0000_0200);
        $display("test reload done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
